// ===== rtl/uie_regs.vh
// Offsets, field positions and reset values of the interrupt enable block
`ifndef UIE_REGS_VH
`define UIE_REGS_VH

`define UIE_ADDR_W 8
`define UIE_DATA_W 32
`define UIE_EV_W 32

`define UIE_OFF_STATUS 8'h0C
`define UIE_OFF_EN_SET 8'h10
`define UIE_OFF_EN_CLR 8'h14

`define UIE_BIT_MASTER 31
`define UIE_BIT_OWNER 30
`define UIE_BIT_ROOT_HUB 6
`define UIE_BIT_FRAME_OVF 5
`define UIE_BIT_UNRECOV 4
`define UIE_BIT_RESUME 3
`define UIE_BIT_SOF 2
`define UIE_BIT_DONE_HEAD 1
`define UIE_BIT_SCHED_OVR 0

`define UIE_EN_MASK 32'hC000007F
`define UIE_EV_MASK 32'h4000007F
`define UIE_EN_RESET 32'h00000000
`define UIE_ST_RESET 32'h00000000
`define UIE_ZERO32 32'h00000000

`endif

// ===== rtl/uie_status.v
// Sticky event status bits, set by hardware and cleared by write-one
`timescale 1ns/100ps
`include "uie_regs.vh"

module uie_status (
    input wire sys_clk,
    input wire reset,
    input wire soft_reset,
    input wire [`UIE_EV_W-1:0] event_set,
    input wire clear_wr,
    input wire [`UIE_EV_W-1:0] clear_data,
    output wire [`UIE_EV_W-1:0] status
);

    reg [`UIE_EV_W-1:0] status_r;
    reg [`UIE_EV_W-1:0] status_nxt;

    always @* begin
        status_nxt = status_r;
        if (clear_wr) begin
            status_nxt = status_nxt & ~clear_data;
        end
        status_nxt = (status_nxt | event_set) & `UIE_EV_MASK;
    end

    always @(posedge sys_clk) begin
        if (reset || soft_reset) begin
            status_r <= `UIE_ST_RESET;
        end else begin
            status_r <= status_nxt;
        end
    end

    assign status = status_r;

endmodule // uie_status

// ===== rtl/uie_top.v
// Interrupt enable set/clear windows and interrupt request gating
`timescale 1ns/100ps
`include "uie_regs.vh"

module uie_top (
    input wire sys_clk,
    input wire reset,
    input wire soft_reset,
    input wire [`UIE_ADDR_W-1:0] reg_addr,
    input wire reg_wr,
    input wire reg_rd,
    input wire [`UIE_DATA_W-1:0] reg_wdata,
    output reg [`UIE_DATA_W-1:0] reg_rdata,
    output reg reg_rvalid,
    input wire ownership_change,
    input wire root_hub_status_change,
    input wire frame_number_overflow,
    input wire unrecoverable_error,
    input wire resume_detect,
    input wire start_of_frame_event,
    input wire done_head_writeback,
    input wire scheduling_overrun,
    output reg irq_req,
    output reg [`UIE_EV_W-1:0] irq_cause,
    output reg master_irq_enable
);

    // Exact byte-offset match, so the windows never alias
    function addr_hit;
        input [`UIE_ADDR_W-1:0] addr;
        input [`UIE_ADDR_W-1:0] off;
        begin
            addr_hit = (addr == off);
        end
    endfunction

    // Keep only the defined bit positions of a word
    function [`UIE_DATA_W-1:0] keep_defined;
        input [`UIE_DATA_W-1:0] word;
        input [`UIE_DATA_W-1:0] mask;
        begin
            keep_defined = word & mask;
        end
    endfunction

    reg [`UIE_DATA_W-1:0] enable_r;
    reg [`UIE_DATA_W-1:0] enable_nxt;
    reg [`UIE_DATA_W-1:0] rdata_nxt;
    reg [`UIE_EV_W-1:0] event_vec;
    wire [`UIE_EV_W-1:0] status_w;
    wire [`UIE_EV_W-1:0] gated_w;
    wire any_gated_w;
    wire set_wr_w;
    wire clr_wr_w;
    wire st_wr_w;
    wire rd_set_w;
    wire rd_clr_w;
    wire rd_st_w;
    reg irq_nxt;
    reg [`UIE_EV_W-1:0] cause_nxt;
    reg mie_nxt;

    assign set_wr_w = reg_wr && addr_hit(reg_addr, `UIE_OFF_EN_SET);
    assign clr_wr_w = reg_wr && addr_hit(reg_addr, `UIE_OFF_EN_CLR);
    assign st_wr_w = reg_wr && addr_hit(reg_addr, `UIE_OFF_STATUS);

    always @* begin
        event_vec = `UIE_ZERO32;
        event_vec[`UIE_BIT_OWNER] = ownership_change;
        event_vec[`UIE_BIT_ROOT_HUB] = root_hub_status_change;
        event_vec[`UIE_BIT_FRAME_OVF] = frame_number_overflow;
        event_vec[`UIE_BIT_UNRECOV] = unrecoverable_error;
        event_vec[`UIE_BIT_RESUME] = resume_detect;
        event_vec[`UIE_BIT_SOF] = start_of_frame_event;
        event_vec[`UIE_BIT_DONE_HEAD] = done_head_writeback;
        event_vec[`UIE_BIT_SCHED_OVR] = scheduling_overrun;
    end

    uie_status u_status (
        .sys_clk(sys_clk),
        .reset(reset),
        .soft_reset(soft_reset),
        .event_set(event_vec),
        .clear_wr(st_wr_w),
        .clear_data(reg_wdata),
        .status(status_w)
    );

    // Set and clear never meet: the two windows are distinct addresses
    always @* begin
        enable_nxt = enable_r;
        if (set_wr_w) begin
            enable_nxt = enable_nxt | reg_wdata;
        end
        if (clr_wr_w) begin
            enable_nxt = enable_nxt & ~reg_wdata;
        end
        // Reserved bits held at zero even if software slips
        enable_nxt = keep_defined(enable_nxt, `UIE_EN_MASK);
    end

    always @(posedge sys_clk) begin
        if (reset || soft_reset) begin
            enable_r <= `UIE_EN_RESET;
        end else begin
            enable_r <= enable_nxt;
        end
    end

    // Per-bit gating, ownership change included
    // Gating stays per bit so the cause word shows every enabled pending source
    genvar gi;
    generate
        for (gi = 0; gi < `UIE_EV_W; gi = gi + 1) begin : g_gate
            assign gated_w[gi] = status_w[gi] & enable_r[gi];
        end
    endgenerate

    // Reserved positions masked again, so no stray bit can raise a request
    assign any_gated_w = |keep_defined(gated_w, `UIE_EV_MASK);

    // Reads have no side effect
    // Read decode kept apart from write decode: a read never touches state
    assign rd_set_w = addr_hit(reg_addr, `UIE_OFF_EN_SET);
    assign rd_clr_w = addr_hit(reg_addr, `UIE_OFF_EN_CLR);
    assign rd_st_w = addr_hit(reg_addr, `UIE_OFF_STATUS);

    always @* begin
        rdata_nxt = `UIE_ZERO32;
        if (rd_set_w) begin
            rdata_nxt = enable_r;
        end else if (rd_clr_w) begin
            rdata_nxt = enable_r;
        end else if (rd_st_w) begin
            rdata_nxt = status_w;
        end else begin
            rdata_nxt = `UIE_ZERO32;
        end
    end

    // Read port ignores the soft reset so a read in flight still answers
    always @(posedge sys_clk) begin
        if (reset) begin
            reg_rvalid <= 1'b0;
        end else begin
            reg_rvalid <= reg_rd;
        end
    end

    // Read data holds the last value read until the next read
    always @(posedge sys_clk) begin
        if (reset) begin
            reg_rdata <= `UIE_ZERO32;
        end else if (reg_rd) begin
            reg_rdata <= rdata_nxt;
        end
    end

    always @* begin
        irq_nxt = any_gated_w & enable_r[`UIE_BIT_MASTER];
        cause_nxt = keep_defined(gated_w, `UIE_EV_MASK);
        mie_nxt = enable_r[`UIE_BIT_MASTER];
    end

    // Level request, one flop after the gating
    // The flop costs a cycle of latency but keeps the request glitch free
    always @(posedge sys_clk) begin
        if (reset || soft_reset) begin
            irq_req <= 1'b0;
        end else begin
            irq_req <= irq_nxt;
        end
    end

    always @(posedge sys_clk) begin
        if (reset || soft_reset) begin
            irq_cause <= `UIE_ZERO32;
        end else begin
            irq_cause <= cause_nxt;
        end
    end

    always @(posedge sys_clk) begin
        if (reset || soft_reset) begin
            master_irq_enable <= 1'b0;
        end else begin
            master_irq_enable <= mie_nxt;
        end
    end

endmodule // uie_top

// ===== bench/uie_props.sv
// Checker for the enable windows and request gating
`timescale 1ns/100ps
module uie_props (
    input wire sys_clk,
    input wire reset,
    input wire soft_reset,
    input wire [7:0] reg_addr,
    input wire reg_wr,
    input wire reg_rd,
    input wire [31:0] reg_wdata,
    input wire reg_rvalid,
    input wire irq_req,
    input wire [31:0] irq_cause,
    input wire master_irq_enable
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (reset || soft_reset);
    sequence s_wr(a);
        reg_wr && reg_addr == a && reg_wdata[31];
    endsequence
    AST_RD: assert property (reg_rd |=> reg_rvalid)
        else $error("read lost");
    AST_PULSE: assert property (!reg_rd |=> !reg_rvalid)
        else $error("stray rvalid");
    AST_GATE: assert property (irq_req |-> irq_cause != 0)
        else $error("request without cause");
    AST_MIE: assert property (
        irq_cause != 0 |-> irq_req == master_irq_enable)
        else $error("master gating wrong");
    AST_SET: assert property (
        s_wr(8'h10) |-> ##[1:2] master_irq_enable) else $error("set lost");
    AST_CLR: assert property (
        s_wr(8'h14) |-> ##[1:2] !master_irq_enable) else $error("clr lost");
    AST_BITS: assert property (irq_cause[29:7] == 0 && !irq_cause[31])
        else $error("reserved cause");
    AST_RST: assert property (disable iff (1'h0) reset |=> !irq_req)
        else $error("request in reset");
    AST_SOFT: assert property (disable iff (reset)
        soft_reset |=> !irq_req && !master_irq_enable)
        else $error("request after soft reset");
endmodule // uie_props
bind uie_top uie_props u_props (.*);

// ===== bench/uie_host.sv
// Host interrupt input: counts clocks with the request high
`timescale 1ns/100ps
module uie_host (
    input wire sys_clk,
    input wire reset,
    input wire irq_req,
    output logic [31:0] irq_cycles = 32'h0
);
    always @(posedge sys_clk) begin
        if (reset)
            irq_cycles <= 32'h0;
        else
            irq_cycles <= irq_cycles + {31'h0, irq_req};
    end
endmodule // uie_host

// ===== bench/usb_host_irq_enable_mask_bench.sv
// Bench: window and event traffic against a model
`timescale 1ns/100ps
module usb_host_irq_enable_mask_bench;
    logic sys_clk = 1'h0, reset = 1'h1, soft_reset = 1'h0, reg_wr = 1'h0;
    logic reg_rd = 1'h0, reg_rvalid, irq_req, master_irq_enable;
    logic [7:0] reg_addr = 8'h00, e = 8'h00;
    logic [31:0] reg_wdata = 32'h0, en = 32'h0, st = 32'h0, reg_rdata;
    logic [31:0] r = 32'h74F48FFB, irq_cause, irq_cycles;
    int fails = 0, comparisons = 0, cyc = 0;
    uie_top DUT (.*, .ownership_change(e[7]),
        .root_hub_status_change(e[6]), .frame_number_overflow(e[5]),
        .unrecoverable_error(e[4]), .resume_detect(e[3]),
        .start_of_frame_event(e[2]), .done_head_writeback(e[1]),
        .scheduling_overrun(e[0]));
    uie_host u_host (.*);
    initial forever #5 sys_clk = ~sys_clk;
    always @(posedge sys_clk) begin
        cyc++;
        if (cyc == 3000) begin
            fails++;
            report_and_stop();
        end
    end
    task automatic chk(input logic [31:0] s, input logic [31:0] x);
        comparisons++;
        if (s !== x) begin
            fails++;
            $display("unexpected at %0t: %h %h", $time, s, x);
        end
    endtask
    task automatic report_and_stop;
        if (fails == 0 && comparisons > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    function automatic logic [31:0] lfsr(input logic [31:0] v);
        return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
    endfunction
    task automatic rd2(input logic [7:0] a, input logic [31:0] x);
        @(posedge sys_clk);
        reg_addr <= a;
        reg_rd <= 1'h1;
        @(posedge sys_clk);
        reg_addr <= a + 8'h04;
        #1;
        chk(reg_rdata, x);
        chk(reg_rvalid, 32'h1);
        @(posedge sys_clk);
        reg_rd <= 1'h0;
        #1;
        chk(reg_rdata, x);
    endtask
    // Address 00h stands for an event pulse, not a write
    // Address 01h is a status clear at 0Ch with the same events pulsed
    task automatic op(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] c0;
        logic q;
        @(posedge sys_clk);
        reg_addr <= (a == 8'h01) ? 8'h0C : a;
        reg_wdata <= d;
        reg_wr <= (a != 8'h00);
        e <= (a[7:1] == 7'h00) ? {d[30], d[6:0]} : 8'h00;
        @(posedge sys_clk);
        reg_wr <= 1'h0;
        e <= 8'h00;
        case (a)
            8'h00: st = st | (d & 32'h4000007F);
            8'h01: st = st | (d & 32'h4000007F);
            8'h0C: st = st & ~d;
            8'h10: en = en | d;
            8'h14: en = en & ~d;
        endcase
        q = en[31] && ((st & en) != 32'h0);
        repeat (2) @(posedge sys_clk);
        #1;
        chk(irq_cause, st & en & 32'h4000007F);
        chk(irq_req, {31'h0, q});
        chk(master_irq_enable, {31'h0, en[31]});
        c0 = irq_cycles;
        @(posedge sys_clk);
        #1;
        chk(irq_cycles - c0, {31'h0, q});
        rd2(8'h10, en);
    endtask
    initial begin
        repeat (20) @(posedge sys_clk);
        reset <= 1'h0;
        rd2(8'h20, 32'h0);
        op(8'h10, 32'hC000007F);
        op(8'h00, 32'h4000007F);
        op(8'h01, 32'h00000004);
        op(8'h14, 32'h80000000);
        @(posedge sys_clk);
        soft_reset <= 1'h1;
        @(posedge sys_clk);
        soft_reset <= 1'h0;
        en = 32'h0;
        st = 32'h0;
        rd2(8'h14, 32'h0);
        for (int i = 0; i < 80; i++) begin
            r = lfsr(r);
            // Reserved bits always written as zero
            op(r[9:8] == 2'h3 ? 8'h00 : 8'h0C + {4'h0, r[9:8], 2'h0},
                r & 32'hC000007F);
        end
        report_and_stop();
    end
endmodule // usb_host_irq_enable_mask_bench
